// [src/wdtdi_watchdog.sv]
// Top of the dual-interface watchdog: I/O-port registers and timer.
// Assumes host I/O writes and reads arrive as one-cycle strobes
// synchronous to clk; cpu_reset_n goes to the board reset logic.
`include "wdtdi_params.svh"

module wdtdi_watchdog
#(
	parameter int SEC_CYCLES = `WDTDI_SEC_CYCLES
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Host I/O port access
	input wire logic [15:0] io_addr,
	input wire logic [7:0] io_wdata,
	input wire logic io_wr,
	input wire logic io_rd,
	output logic [7:0] io_rdata,
	output logic io_rdata_valid,
	// Watchdog state and CPU reset
	output logic wd_enabled,
	output logic cpu_reset_n
);
	logic wr_legacy_timeout;
	logic wr_legacy_retrig;
	logic wr_unit_select;
	logic wr_timeout_value;

	wdtdi_port_decode u_decode
	(
		.io_addr(io_addr),
		.io_wr(io_wr),
		.wr_legacy_timeout(wr_legacy_timeout),
		.wr_legacy_retrig(wr_legacy_retrig),
		.wr_unit_select(wr_unit_select),
		.wr_timeout_value(wr_timeout_value)
	);

	logic [7:0] unit_select;
	logic [7:0] timeout_value;
	logic [7:0] remaining;
	logic [7:0] reload_count;
	logic count_seconds;
	logic [4:0] pulse_count;
	wdtdi_pkg::wdtdi_state_t state;
	wdtdi_pkg::wdtdi_state_t next_state;

	logic sec_tick;
	logic min_tick;

	// Write of a value to either timeout port
	wire adv_nonzero = wr_timeout_value && (io_wdata != `WDTDI_ZERO_BYTE);
	wire adv_zero = wr_timeout_value && (io_wdata == `WDTDI_ZERO_BYTE);
	wire leg_enable = wr_legacy_timeout &&
		(io_wdata == `WDTDI_LEGACY_ENABLE);
	wire leg_zero = wr_legacy_timeout && (io_wdata == `WDTDI_ZERO_BYTE);
	wire running = (state == wdtdi_pkg::WDTDI_RUN);
	// RL2 RL7 enable and disable
	wire start = adv_nonzero || leg_enable;
	wire stop = adv_zero || leg_zero;
	// RL3 RL8 service restarts interval
	wire retrig = running && wr_legacy_retrig;
	wire restart = start || retrig;

	// RL6 unit choice per interface
	wire unit_sec = unit_select[`WDTDI_UNIT_BIT];
	wire tick = count_seconds ? sec_tick : min_tick;
	wire expire = running && tick &&
		(remaining == `WDTDI_COUNT_STEP) && !restart;
	wire pulse_done = (pulse_count == 5'(`WDTDI_RESET_PULSE - 1));

	wdtdi_prescaler #(.SEC_CYCLES(SEC_CYCLES)) u_prescaler
	(
		.clk(clk),
		.reset_n(reset_n),
		.restart(restart),
		.sec_tick(sec_tick),
		.min_tick(min_tick)
	);

	always_comb
	begin
		next_state = state;
		unique case (state)
			wdtdi_pkg::WDTDI_OFF:
				if (start)
					next_state = wdtdi_pkg::WDTDI_RUN;
			wdtdi_pkg::WDTDI_RUN:
				if (stop)
					next_state = wdtdi_pkg::WDTDI_OFF;
				else if (expire)
					next_state = wdtdi_pkg::WDTDI_FIRE;
			wdtdi_pkg::WDTDI_FIRE:
				if (pulse_done)
					next_state = wdtdi_pkg::WDTDI_OFF;
			default:
				next_state = wdtdi_pkg::WDTDI_OFF;
		endcase
	end

	// RL10 disabled after reset
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			state <= wdtdi_pkg::WDTDI_OFF;
		else
			state <= next_state;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			unit_select <= `WDTDI_UNIT_RESET;
		else if (wr_unit_select)
			unit_select <= io_wdata;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			timeout_value <= `WDTDI_ZERO_BYTE;
		else if (wr_timeout_value)
			timeout_value <= io_wdata;
	end

	// RL5 RL6 load count and unit
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			remaining <= `WDTDI_ZERO_BYTE;
			count_seconds <= 1'b1;
		end
		else if (adv_nonzero)
		begin
			remaining <= io_wdata;
			count_seconds <= unit_sec;
		end
		else if (leg_enable)
		begin
			remaining <= `WDTDI_LEGACY_SECONDS;
			count_seconds <= 1'b1;
		end
		else if (retrig)
			remaining <= reload_count;
		else if (running && tick && remaining != `WDTDI_ZERO_BYTE)
			remaining <= remaining - `WDTDI_COUNT_STEP;
	end

	// RL3 RL8 interval to restart from
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			reload_count <= `WDTDI_ZERO_BYTE;
		else if (adv_nonzero)
			reload_count <= io_wdata;
		else if (leg_enable)
			reload_count <= `WDTDI_LEGACY_SECONDS;
	end

	// RL4 timed reset pulse
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			pulse_count <= 5'h00;
		else if (state == wdtdi_pkg::WDTDI_FIRE)
			pulse_count <= pulse_count + 5'h01;
		else
			pulse_count <= 5'h00;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cpu_reset_n <= 1'b1;
			wd_enabled <= 1'b0;
		end
		else
		begin
			cpu_reset_n <= (next_state != wdtdi_pkg::WDTDI_FIRE);
			wd_enabled <= (next_state == wdtdi_pkg::WDTDI_RUN);
		end
	end

	// Readback of advanced registers; others read zero
	wire rd_unit = io_addr == `WDTDI_ADDR_UNIT_SELECT;
	wire rd_value = io_addr == `WDTDI_ADDR_TIMEOUT_VALUE;
	wire [7:0] rd_mux = rd_unit ? unit_select :
		(rd_value ? timeout_value : `WDTDI_ZERO_BYTE);

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			io_rdata <= `WDTDI_ZERO_BYTE;
			io_rdata_valid <= 1'b0;
		end
		else
		begin
			io_rdata <= io_rd ? rd_mux : `WDTDI_ZERO_BYTE;
			io_rdata_valid <= io_rd;
		end
	end
endmodule

// [shared/wdtdi_params.svh]
// Constants for the dual-interface watchdog: port addresses, codes, timing.
// Assumes a 125 MHz system clock and 16-bit I/O-port addressing.
// Operation
// RL1 - Two register interfaces, advanced and legacy, drive one shared timer.
// RL2 - A nonzero write to the timeout register enables, a zero write disables.
// RL3 - Software services the timer by rewriting the timeout, which restarts it.
// RL4 - An enabled timer left unserviced past its interval resets the CPU.
// RL5 - The interval spans one second to 255 minutes from an 8-bit count.
// RL6 - Unit-select bit 7 low counts minutes, high counts seconds.
// RL7 - Legacy timeout port: zero disables, 01h enables a two-second interval.
// RL8 - Any write to the legacy retrigger port restarts the interval.
// RL9 - Software should pick a long timeout when booting with the timer on.
// RL10 - A prescaled tick gives exact seconds and minutes; reset clears all.
`ifndef WDTDI_PARAMS_SVH
`define WDTDI_PARAMS_SVH

`define WDTDI_ADDR_LEGACY_TIMEOUT 16'h01EE
`define WDTDI_ADDR_LEGACY_RETRIG 16'h01EF
`define WDTDI_ADDR_UNIT_SELECT 16'h0565
`define WDTDI_ADDR_TIMEOUT_VALUE 16'h0566

`define WDTDI_UNIT_BIT 7
`define WDTDI_LEGACY_ENABLE 8'h01
`define WDTDI_LEGACY_SECONDS 8'h02
`define WDTDI_ZERO_BYTE 8'h00
`define WDTDI_UNIT_RESET 8'h00
`define WDTDI_COUNT_STEP 8'h01

// One second at 125 MHz, in clock cycles
`define WDTDI_CLK_HZ 125000000
`define WDTDI_SEC_MS 1000
`define WDTDI_SEC_CYCLES ((`WDTDI_CLK_HZ / 1000) * `WDTDI_SEC_MS)
`define WDTDI_SEC_PER_MIN 60
// Length of the CPU reset pulse, in clock cycles
`define WDTDI_RESET_PULSE 16

`endif

// [shared/wdtdi_pkg.sv]
// Types for the dual-interface watchdog.
// Assumes the params header supplies all numbers except the one-hot state codes set here.
package wdtdi_pkg;
	typedef enum logic [2:0]
	{
		WDTDI_OFF = 3'b001,
		WDTDI_RUN = 3'b010,
		WDTDI_FIRE = 3'b100
	} wdtdi_state_t;
endpackage

// [src/wdtdi_prescaler.sv]
// Tick generator: one pulse per second, and one per minute.
// Assumes a synchronous clear on every watchdog restart.
`include "wdtdi_params.svh"

module wdtdi_prescaler
#(
	parameter int SEC_CYCLES = `WDTDI_SEC_CYCLES
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Control
	input wire logic restart,
	// Ticks
	output logic sec_tick,
	output logic min_tick
);
	localparam int SEC_W = $clog2(SEC_CYCLES);
	localparam logic [SEC_W-1:0] SEC_LAST = SEC_W'(SEC_CYCLES - 1);
	localparam logic [5:0] MIN_LAST = 6'(`WDTDI_SEC_PER_MIN - 1);

	logic [SEC_W-1:0] sec_count;
	logic [5:0] min_count;
	wire sec_wrap = (sec_count == SEC_LAST);
	wire min_wrap = sec_wrap && (min_count == MIN_LAST);

	// RL10 exact second base
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			sec_count <= '0;
		else if (restart || sec_wrap)
			sec_count <= '0;
		else
			sec_count <= sec_count + SEC_W'(1);
	end

	// RL10 exact minute base
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			min_count <= '0;
		else if (restart || min_wrap)
			min_count <= '0;
		else if (sec_wrap)
			min_count <= min_count + 6'h01;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sec_tick <= 1'b0;
			min_tick <= 1'b0;
		end
		else
		begin
			sec_tick <= sec_wrap && !restart;
			min_tick <= min_wrap && !restart;
		end
	end
endmodule

// [src/wdtdi_port_decode.sv]
// I/O-port write decoder for the two watchdog interfaces.
// Assumes one-cycle write and read strobes with a stable address.
`include "wdtdi_params.svh"

module wdtdi_port_decode
(
	// Bus request
	input wire logic [15:0] io_addr,
	input wire logic io_wr,
	// Decoded writes
	output logic wr_legacy_timeout,
	output logic wr_legacy_retrig,
	output logic wr_unit_select,
	output logic wr_timeout_value
);
	// RL1 both interfaces decoded here
	assign wr_legacy_timeout = io_wr &&
		(io_addr == `WDTDI_ADDR_LEGACY_TIMEOUT);
	assign wr_legacy_retrig = io_wr &&
		(io_addr == `WDTDI_ADDR_LEGACY_RETRIG);
	assign wr_unit_select = io_wr && (io_addr == `WDTDI_ADDR_UNIT_SELECT);
	assign wr_timeout_value = io_wr &&
		(io_addr == `WDTDI_ADDR_TIMEOUT_VALUE);
endmodule

// [bench/wdtdi_chk.sv]
// Checker on the watchdog top ports.
// Assumes one clock domain with async active-low reset.
module wdtdi_chk
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Host bus
	input wire logic [15:0] io_addr,
	input wire logic [7:0] io_wdata,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_rdata,
	input wire logic io_rdata_valid,
	// Timer
	input wire logic wd_enabled,
	input wire logic cpu_reset_n
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	wire adv = io_wr && io_addr == 16'h0566;
	wire leg = io_wr && io_addr == 16'h01EE;
	wire mapped = io_addr == 16'h0565 || io_addr == 16'h0566;
	a_read_answer: assert property (io_rd |=> io_rdata_valid)
		else $error("read not answered");
	a_valid_cause: assert property (io_rdata_valid |-> $past(io_rd))
		else $error("valid without read");
	a_rdata_idle: assert property (!io_rdata_valid |-> !io_rdata)
		else $error("read data not zero");
	a_unmapped_zero: assert property (io_rd && !mapped |=> !io_rdata)
		else $error("unmapped read not zero");
	a_adv_enable: assert property (adv && io_wdata |=> wd_enabled)
		else $error("nonzero write did not enable");
	a_adv_disable: assert property (adv && !io_wdata |=> !wd_enabled)
		else $error("zero write did not disable");
	a_leg_enable: assert property (leg && io_wdata == 8'h01 |=> wd_enabled)
		else $error("legacy enable failed");
	a_leg_disable: assert property (leg && !io_wdata |=> !wd_enabled)
		else $error("legacy disable failed");
	a_fire_cause: assert property ($fell(cpu_reset_n) |-> $past(wd_enabled))
		else $error("reset while disabled");
	a_pulse_len: assert property ($fell(cpu_reset_n) |->
		(!cpu_reset_n)[*8] ##1 (!cpu_reset_n)[*8] ##1 cpu_reset_n)
		else $error("cpu reset pulse length");
endmodule

bind wdtdi_watchdog wdtdi_chk chk (.clk, .reset_n, .io_addr, .io_wdata,
	.io_wr, .io_rd, .io_rdata, .io_rdata_valid, .wd_enabled, .cpu_reset_n);

// [bench/wdtdi_host.sv]
// Host software model driving byte I/O port cycles.
// Assumes the bench calls its tasks; changes land on falling edges.
module wdtdi_host
(
	// Clock
	input wire logic clk,
	// Read return
	input wire logic [7:0] io_rdata,
	input wire logic io_rdata_valid,
	// Bus request
	output logic [15:0] io_addr,
	output logic [7:0] io_wdata,
	output logic io_wr,
	output logic io_rd
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		io_addr = 16'h0000;
		io_wdata = 8'h00;
		io_wr = 1'h0;
		io_rd = 1'h0;
	end
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk);
		io_addr = a;
		io_wdata = d;
		io_wr = 1'h1;
		@(negedge clk);
		io_wr = 1'h0;
		io_addr = ~a;
		io_wdata = ~d;
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] d,
		output logic v);
		@(negedge clk);
		io_addr = a;
		io_rd = 1'h1;
		@(negedge clk);
		io_rd = 1'h0;
		io_addr = ~a;
		d = io_rdata;
		v = io_rdata_valid;
	endtask
endmodule

// [bench/watchdog_dual_interface_bench.sv]
// Self-checking bench for the dual-interface watchdog.
// Assumes a second shortened to eight clocks so that expiry is reached.
module watchdog_dual_interface_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, reset_n, io_wr, io_rd, io_rdata_valid, wd_enabled;
	logic cpu_reset_n, v;
	logic [15:0] io_addr;
	logic [7:0] io_wdata, io_rdata, d;
	int n_errors, total_checks;
	localparam int SEC_CYC = 8;
	localparam int MIN_CYC = 60 * SEC_CYC;
	localparam int PULSE = 16;
	logic [7:0] codes [6] = '{8'h01, 8'h03, 8'h1E, 8'h04, 8'h05, 8'hFF};
	logic [7:0] units [6] = '{8'h80, 8'h80, 8'h80, 8'h00, 8'h00, 8'h80};
	wdtdi_watchdog #(.SEC_CYCLES(SEC_CYC)) uut (.clk, .reset_n, .io_addr,
		.io_wdata, .io_wr, .io_rd, .io_rdata, .io_rdata_valid, .wd_enabled,
		.cpu_reset_n);
	wdtdi_host host (.clk, .io_rdata, .io_rdata_valid, .io_addr,
		.io_wdata, .io_wr, .io_rd);
	initial
	begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
		host.rd(a, d, v);
		chk({7'h00, v}, 8'h01);
		chk(d, e);
	endtask
	task automatic wrchk(input logic [15:0] a, input logic [7:0] x,
		input logic en);
		host.wr(a, x);
		chk({7'h00, wd_enabled}, {7'h00, en});
	endtask
	task automatic expect_fire(input int t);
		repeat (t - 1) @(negedge clk);
		chk({7'h00, cpu_reset_n}, 8'h01);
		@(negedge clk);
		chk({7'h00, cpu_reset_n}, 8'h00);
		repeat (PULSE - 1) @(negedge clk);
		chk({7'h00, cpu_reset_n}, 8'h00);
		@(negedge clk);
		chk({6'h00, wd_enabled, cpu_reset_n}, 8'h01);
	endtask
	task automatic t_leg_fire;
		wrchk(16'h01EE, 8'h01, 1'h1);
		repeat (2 * SEC_CYC - 2) @(negedge clk);
		wrchk(16'h01EF, 8'h3C, 1'h1);
		expect_fire(2 * SEC_CYC + 1);
	endtask
	task automatic t_reset;
		@(negedge clk);
		reset_n = 1'h0;
		repeat (5) @(negedge clk);
		reset_n = 1'h1;
		chk({6'h00, wd_enabled, cpu_reset_n}, 8'h01);
		rdchk(16'h0565, 8'h00);
		rdchk(16'h0566, 8'h00);
	endtask
	task automatic t_adv;
		wrchk(16'h0565, 8'h80, 1'h0);
		wrchk(16'h0566, 8'h1E, 1'h1);
		rdchk(16'h0565, 8'h80);
		rdchk(16'h0566, 8'h1E);
		wrchk(16'h0566, 8'h00, 1'h0);
	endtask
	task automatic t_legacy;
		wrchk(16'h01EE, 8'h01, 1'h1);
		wrchk(16'h01EF, 8'h5A, 1'h1);
		rdchk(16'h01EE, 8'h00);
		wrchk(16'h0566, 8'h00, 1'h0);
		wrchk(16'h01EF, 8'hA5, 1'h0);
		wrchk(16'h01EE, 8'h01, 1'h1);
		wrchk(16'h01EE, 8'h00, 1'h0);
	endtask
	task automatic t_unmapped;
		rdchk(16'h0564, 8'h00);
		wrchk(16'h0567, 8'hFF, 1'h0);
		rdchk(16'h01EF, 8'h00);
	endtask
	task automatic t_service;
		int t;
		for (int i = 0; i < 6; i++)
		begin
			t = codes[i] * (units[i][7] ? SEC_CYC : MIN_CYC) + 1;
			host.wr(16'h0565, units[i]);
			wrchk(16'h0566, codes[i], 1'h1);
			repeat (t - 3) @(negedge clk);
			chk({7'h00, cpu_reset_n}, 8'h01);
			wrchk(16'h0566, codes[i], 1'h1);
			expect_fire(t);
		end
		wrchk(16'h0566, 8'h00, 1'h0);
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		reset_n = 1'h0;
		t_reset;
		t_adv;
		t_legacy;
		t_leg_fire;
		t_unmapped;
		t_service;
		wrchk(16'h0566, 8'h05, 1'h1);
		t_reset;
		complete_run;
	end
	initial
	begin
		repeat (40000) @(posedge clk);
		n_errors++;
		complete_run;
	end
endmodule
